// >>> ciaf_accept.v
// interrupt acceptance flags: mask gate, stack select, priority level
// Functional notes
// RULE1 - gate flag zero blocks maskable requests
// RULE2 - any acknowledge clears the gate flag
// RULE3 - stack select picks system or task pointer
// RULE4 - hardware ack or trap 0-31 clears select
// RULE5 - priority level is three bits, 0 to 7
// RULE6 - accept only strictly higher request priority
// RULE7 - save flags before clearing on acknowledge
`include "ciaf_defines.vh"
module ciaf_accept #(
   parameter LVL_W = `CIAF_LVL_W,
   parameter VEC_W = `CIAF_VEC_W,
   parameter SP_W  = `CIAF_SP_W
) (
   input  wire                  clock,
   input  wire                  nrst,
   input  wire                  irq_valid,
   input  wire                  irq_maskable,
   input  wire [LVL_W-1:0]      irq_level,
   input  wire                  trap_exec,
   input  wire [VEC_W-1:0]      trap_vector,
   input  wire                  flag_wr,
   input  wire                  gate_wr,
   input  wire                  sel_wr,
   input  wire [LVL_W-1:0]      lvl_wr,
   input  wire                  restore,
   input  wire [SP_W-1:0]       system_stack_ptr,
   input  wire [SP_W-1:0]       task_stack_ptr,
   output reg                   irq_ack,
   output reg                   gate_flag,
   output reg                   sel_flag,
   output reg  [LVL_W-1:0]      cpu_priority_level,
   output reg  [SP_W-1:0]       active_stack_ptr,
   output reg  [LVL_W+1:0]      saved_flags
);

   localparam SAVE_W = LVL_W + 2;

   // true when a request may be taken this cycle
   function accept_ok;
      input             g;
      input             m;
      input [LVL_W-1:0] req;
      input [LVL_W-1:0] cur;
      begin
         accept_ok = (!m || g) && (req > cur); // [RULE1] [RULE6] [RULE5]
      end
   endfunction

   // true for trap vectors that also force the system pointer
   function trap_in_low;
      input [VEC_W-1:0] vec;
      begin
         trap_in_low = (vec <= `CIAF_TRAP_LAST);
      end
   endfunction

   reg                  gate_nxt;
   reg                  sel_nxt;
   reg  [LVL_W-1:0]     lvl_nxt;
   reg                  take;
   reg                  trap_low;
   reg  [SAVE_W-1:0]    saved_nxt;
   wire [SP_W-1:0]      ptr_nxt;

   // acceptance decision
   always @* begin
      take = 1'b0;
      // a pulse already out blocks a second take until the next cycle
      if (irq_valid && !irq_ack) begin
         if (accept_ok(gate_flag, irq_maskable, irq_level, cpu_priority_level)) begin
            take = 1'b1;
         end
      end
   end

   // trap vector range decode
   always @* begin
      trap_low = 1'b0;
      if (trap_exec) begin
         trap_low = trap_in_low(trap_vector);
      end
   end

   // mask gate flag
   always @* begin
      gate_nxt = gate_flag;
      // software writes apply first so acknowledge clears always win
      if (restore) begin
         gate_nxt = saved_flags[`CIAF_SAVE_GATE];
      end else if (flag_wr) begin
         gate_nxt = gate_wr;
      end
      if (take) begin
         gate_nxt = 1'b0; // [RULE2]
      end
      if (trap_exec) begin
         gate_nxt = 1'b0; // [RULE2]
      end
   end

   // stack select flag
   always @* begin
      sel_nxt = sel_flag;
      if (restore) begin
         sel_nxt = saved_flags[`CIAF_SAVE_SEL];
      end else if (flag_wr) begin
         sel_nxt = sel_wr;
      end
      if (take) begin
         sel_nxt = 1'b0; // [RULE4]
      end
      if (trap_low) begin
         sel_nxt = 1'b0; // [RULE4]
      end
   end

   // processor priority level
   always @* begin
      lvl_nxt = cpu_priority_level;
      if (restore) begin
         lvl_nxt = saved_flags[`CIAF_SAVE_LVL_LO +: LVL_W];
      end else if (flag_wr) begin
         lvl_nxt = lvl_wr;
      end
      // traps leave the level alone; only a taken request, a flag write or a restore changes it
      if (take) begin
         lvl_nxt = irq_level; // [RULE5]
      end
   end

   // copy of the flags as they stood before this acknowledge
   always @* begin
      saved_nxt = saved_flags;
      if (take || trap_exec) begin
         saved_nxt = {cpu_priority_level, sel_flag, gate_flag}; // [RULE7]
      end
   end

   // per-bit pointer select, driven by the flag value about to be stored
   genvar gi;
   generate
      for (gi = 0; gi < SP_W; gi = gi + 1) begin : g_ptr
         assign ptr_nxt[gi] = sel_nxt ? task_stack_ptr[gi] : system_stack_ptr[gi]; // [RULE3]
      end
   endgenerate

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irq_ack <= 1'b0;
      end else begin
         irq_ack <= take;
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         gate_flag <= `CIAF_GATE_RST;
      end else begin
         gate_flag <= gate_nxt;
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sel_flag <= `CIAF_SEL_RST;
      end else begin
         sel_flag <= sel_nxt;
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cpu_priority_level <= `CIAF_LVL_RST;
      end else begin
         cpu_priority_level <= lvl_nxt;
      end
   end

   // the pointer lands in the same cycle as the flag that chose it
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         active_stack_ptr <= {SP_W{1'b0}};
      end else begin
         active_stack_ptr <= ptr_nxt;
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         saved_flags <= {SAVE_W{1'b0}};
      end else begin
         saved_flags <= saved_nxt;
      end
   end

endmodule

// >>> ciaf_checker.sv
// assertions on the interrupt acceptance flag outputs
module ciaf_chk(input wire clock,nrst,irq_valid,irq_maskable,irq_ack,gate_flag,sel_flag,
input wire [2:0] irq_level,cpu_priority_level);
default clocking @(posedge clock); endclocking
default disable iff (!nrst);
chk_mask_block: assert property (irq_ack |-> $past(gate_flag|!irq_maskable)) else $error("masked ack");
chk_gate_holds: assert property (irq_valid&&irq_maskable&&!gate_flag |=> !irq_ack) else $error("gate open");
chk_ack_clear: assert property (irq_ack |-> !gate_flag&&!sel_flag) else $error("flags kept");
chk_lvl_higher: assert property (irq_ack |-> $past(irq_level)>$past(cpu_priority_level)) else $error("low ack");
chk_ack_lvl: assert property (irq_ack |-> cpu_priority_level==$past(irq_level)) else $error("bad level");
chk_take_req: assert property (irq_valid&&!irq_ack&&(gate_flag|!irq_maskable)&&irq_level>cpu_priority_level
 |=> irq_ack) else $error("no ack");
endmodule
bind ciaf_accept ciaf_chk chk_u(.*);

// >>> ciaf_defines.vh
// constants for the cpu interrupt acceptance flag block
`ifndef CIAF_DEFINES_VH
`define CIAF_DEFINES_VH
`define CIAF_LVL_W        3
`define CIAF_VEC_W        6
`define CIAF_SP_W         16
`define CIAF_TRAP_LAST    6'h1F
`define CIAF_GATE_RST     1'b0
`define CIAF_SEL_RST      1'b0
`define CIAF_LVL_RST      3'h0
`define CIAF_SAVE_W       5
`define CIAF_SAVE_GATE    0
`define CIAF_SAVE_SEL     1
`define CIAF_SAVE_LVL_LO  2
`endif

// >>> ciaf_src.sv
// interrupt source model: holds a request until it is acknowledged
module ciaf_src(input wire clock,go,m,irq_ack,input wire [2:0] lv,
output logic irq_valid=0,irq_maskable=0,output logic [2:0] irq_level=0);
always @(posedge clock) if (go) begin irq_valid<=1; irq_maskable<=m; irq_level<=lv; end
else if (irq_ack) begin irq_valid<=0; irq_level<=~irq_level; end
endmodule

// >>> tb_cpu_interrupt_accept_flags.sv
// testbench for the interrupt acceptance flags
module tb_cpu_interrupt_accept_flags;
timeunit 1ns; timeprecision 1ns;
logic clock=0,nrst=0,go=0,m=0,trap_exec=0,flag_wr=0,gate_wr=0,sel_wr=0,irq_valid,irq_maskable,irq_ack,gf,sf;
logic [2:0] lv=0,lvl_wr=0,irq_level,pl; logic [5:0] tv=0; logic [15:0] asp; logic [4:0] sv;
logic [31:0] r=32'h5A1B; logic [9:0] q[$]; int num_errors=0,checks=0,cyc=0;
always #5 clock=~clock;
ciaf_accept dut_u(.clock,.nrst,.irq_valid,.irq_maskable,.irq_level,.trap_exec,.trap_vector(tv),.flag_wr,.gate_wr,
.sel_wr,.lvl_wr,.restore(1'b0),.system_stack_ptr(16'h1234),.task_stack_ptr(16'hABCD),.irq_ack,.gate_flag(gf),
.sel_flag(sf),.cpu_priority_level(pl),.active_stack_ptr(asp),.saved_flags(sv));
ciaf_src src_u(.clock,.go,.m,.irq_ack,.lv,.irq_valid,.irq_maskable,.irq_level);
task cmp(input logic [15:0] a,e); checks++;
if (a!==e) begin num_errors++; $display("Error %0t: got %h want %h",$time,a,e); end endtask
function logic [31:0] lfsr(input logic [31:0] s); return {s[30:0],s[31]^s[21]^s[1]^s[0]}; endfunction
task give_verdict; if (q.size()!=0) num_errors++; $display("checks %0d errors %0d",checks,num_errors);
if (num_errors==0&&checks>0) $display("*** PASS ***"); else $display("*** FAIL ***"); $finish; endtask
task fw(input logic g,s,input logic [2:0] l); @(posedge clock) begin flag_wr<=1; gate_wr<=g; sel_wr<=s; lvl_wr<=l; end
@(posedge clock) flag_wr<=0; endtask
task rq(input logic mm,input logic [2:0] l); @(posedge clock) begin go<=1; m<=mm; lv<=l; end
@(posedge clock) go<=0; repeat(4) @(posedge clock); endtask
task tp(input logic [5:0] v,input logic s); @(posedge clock) begin trap_exec<=1; tv<=v; end
@(posedge clock) trap_exec<=0; #1 cmp({gf,sf},{1'b0,s}); endtask
always @(posedge clock) begin cyc<=cyc+1; if (cyc>3000) begin num_errors++; give_verdict; end
#1 if (irq_ack===1'b1) cmp({pl,gf,sf,sv},q.pop_front()); end
initial begin repeat(16) @(posedge clock); nrst<=1;
fw(1,1,2); repeat(2) @(posedge clock); #1 cmp(asp,16'hABCD);
rq(1,2); q.push_back({5'd8,5'b00111}); fw(1,1,1); rq(1,5);
q.push_back({5'd20,5'b01001}); fw(1,0,2); repeat(3) @(posedge clock); $display("mask and level done");
for (int i=0;i<6;i++) begin r=lfsr(r); fw(1,1,0);
q.push_back({r[2:0]|3'd1,2'b00,5'b00011}); rq(r[3],r[2:0]|3'd1); end
fw(0,1,0); q.push_back({3'd3,2'b00,5'b00010}); rq(0,3); $display("non-maskable done");
fw(1,1,0); tp(6'd40,1); tp(6'd31,0); $display("trap done"); give_verdict; end
endmodule
